//--- logic/serial_terminal_interface.sv
`timescale 1ns/100ps
module serial_terminal_interface #(
  parameter int UNIT_CYCLES = sti_pkg::UNIT_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire sti_pkg::bus_req_t bus_req,
  output logic [7:0]            bus_rdata,
  output logic                  bus_ack,
  input  wire logic             poll,
  input  wire logic [2:0]       poll_pos,
  output logic                  poll_ack,
  output logic [7:0]            poll_vector,
  output logic                  irq,
  input  wire logic             line_rx,
  output logic                  line_tx
);

  localparam int CW = 24;

  function automatic logic [CW-1:0] to_cw(input int v);
    to_cw = v[CW-1:0];
  endfunction : to_cw

  logic [CW-1:0]      unit_last;
  logic [CW-1:0]      half_last;
  assign unit_last = to_cw(UNIT_CYCLES - 1);
  assign half_last = to_cw(UNIT_CYCLES / 2 - 1);

  // Every strobe compares the full address, so no register is reached through an alias.
  function automatic logic addr_hit(input logic        strobe,
                                    input logic [15:0] addr,
                                    input logic [15:0] base);
    addr_hit = strobe && (addr == base);
  endfunction : addr_hit

  // Status byte assembly, shared by both halves.
  function automatic logic [7:0] status_byte(input logic done,
                                             input logic bit6);
    logic [7:0] s;
    s                     = sti_pkg::STATUS_RESET;
    s[sti_pkg::DONE_BIT]  = done;
    s[sti_pkg::ERROR_BIT] = bit6;
    status_byte           = s;
  endfunction : status_byte

  logic rd_kin;
  logic rd_kst;
  logic rd_pst;
  logic wr_kst;
  logic wr_pst;
  logic wr_pout;
  assign rd_kin  = addr_hit(bus_req.rd, bus_req.addr, sti_pkg::KEY_INPUT_ADDR);
  assign rd_kst  = addr_hit(bus_req.rd, bus_req.addr, sti_pkg::KEY_STATUS_ADDR);
  assign rd_pst  = addr_hit(bus_req.rd, bus_req.addr, sti_pkg::PRINT_STATUS_ADDR);
  assign wr_kst  = addr_hit(bus_req.wr, bus_req.addr, sti_pkg::KEY_STATUS_ADDR);
  assign wr_pst  = addr_hit(bus_req.wr, bus_req.addr, sti_pkg::PRINT_STATUS_ADDR);
  assign wr_pout = addr_hit(bus_req.wr, bus_req.addr, sti_pkg::PRINT_OUTPUT_ADDR);

  // Receiver.
  sti_pkg::rx_state_t rx_state_reg;
  logic [CW-1:0]      rx_cnt_reg;
  logic [3:0]         rx_bit_reg;
  logic [7:0]         rx_shift_reg;
  logic [7:0]         key_input_buffer_reg;
  logic               rx_done_pulse;
  logic               rx_line_q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_line_q_reg <= 1'b1;
    end else begin
      rx_line_q_reg <= line_rx;
    end
  end

  logic rx_half_end;
  logic rx_cnt_end;
  assign rx_half_end = rx_cnt_reg == half_last;
  assign rx_cnt_end  = rx_cnt_reg == unit_last;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= sti_pkg::RX_IDLE;
    end else begin
      case (rx_state_reg)
        sti_pkg::RX_IDLE: begin
          if (!rx_line_q_reg) begin
            rx_state_reg <= sti_pkg::RX_START; // [RULE5]
          end
        end
        sti_pkg::RX_START: begin
          // A glitch shorter than half a unit is dropped as noise.
          if (rx_half_end) begin
            rx_state_reg <= rx_line_q_reg ? sti_pkg::RX_IDLE : sti_pkg::RX_DATA;
          end
        end
        sti_pkg::RX_DATA: begin
          if (rx_cnt_end && rx_bit_reg == 4'(sti_pkg::DATA_BITS - 1)) begin
            rx_state_reg <= sti_pkg::RX_STOP;
          end
        end
        sti_pkg::RX_STOP: begin
          // Only the middle of the first stop unit is waited for, without checking the line, so back-to-back frames keep sync.
          if (rx_cnt_end) begin
            rx_state_reg <= sti_pkg::RX_IDLE;
          end
        end
        default: rx_state_reg <= sti_pkg::RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt_reg <= '0;
    end else if (rx_state_reg == sti_pkg::RX_IDLE) begin
      rx_cnt_reg <= '0;
    end else if ((rx_state_reg == sti_pkg::RX_START && rx_half_end) || rx_cnt_end) begin
      rx_cnt_reg <= '0;
    end else begin
      rx_cnt_reg <= rx_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_bit_reg <= 4'h0;
    end else if (rx_state_reg == sti_pkg::RX_START && rx_half_end) begin
      rx_bit_reg <= 4'h0;
    end else if (rx_state_reg == sti_pkg::RX_DATA && rx_cnt_end) begin
      rx_bit_reg <= rx_bit_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_reg <= 8'h00;
    end else if (rx_state_reg == sti_pkg::RX_DATA && rx_cnt_end) begin
      rx_shift_reg <= {rx_line_q_reg, rx_shift_reg[7:1]}; // [RULE5] [RULE1]
    end
  end

  assign rx_done_pulse = rx_state_reg == sti_pkg::RX_STOP && rx_cnt_end;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_input_buffer_reg <= 8'h00;
    end else if (rx_done_pulse) begin
      key_input_buffer_reg <= rx_shift_reg; // [RULE3]
    end
  end

  // Input status.
  logic key_done_reg, key_err_reg, key_ie_reg, key_req_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_done_reg <= 1'b0;
    end else if (rx_done_pulse) begin
      key_done_reg <= 1'b1; // [RULE8]
    end else if (rd_kin) begin
      key_done_reg <= 1'b0; // [RULE9]
    end
  end

  // A read in the same cycle as a new character counts as served in time.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_err_reg <= 1'b0;
    end else if (rx_done_pulse && key_done_reg && !rd_kin) begin
      key_err_reg <= 1'b1; // [RULE10]
    end else if (rd_kin) begin
      key_err_reg <= 1'b0; // [RULE9]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_ie_reg <= 1'b0;
    end else if (wr_kst) begin
      key_ie_reg <= bus_req.wdata[sti_pkg::IE_BIT]; // [RULE20]
    end
  end

  logic key_rise;
  assign key_rise = rx_done_pulse && (!key_done_reg || !key_err_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_req_reg <= 1'b0;
    end else if (key_ie_reg && key_rise) begin
      key_req_reg <= 1'b1; // [RULE12]
    end else if (rd_kst) begin
      key_req_reg <= 1'b0; // [RULE14]
    end
  end

  // Transmitter. A write while busy is dropped so a frame is never torn.
  logic [10:0]   tx_frame_reg;
  logic [3:0]    tx_units_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic          tx_busy_reg;
  logic          tx_load;
  logic          tx_unit_end;
  logic          tx_end;

  assign tx_load     = wr_pout && !tx_busy_reg;
  assign tx_unit_end = tx_busy_reg && tx_cnt_reg == unit_last;
  assign tx_end      = tx_unit_end && tx_units_reg == 4'(sti_pkg::FRAME_UNITS - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_frame_reg <= 11'h7FF;
    end else if (tx_load) begin
      tx_frame_reg <= {2'b11, bus_req.wdata, 1'b0}; // [RULE15] [RULE5] [RULE3]
    end else if (tx_unit_end) begin
      tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_units_reg <= 4'h0;
    end else if (tx_load) begin
      tx_units_reg <= 4'h0;
    end else if (tx_unit_end) begin
      tx_units_reg <= tx_units_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cnt_reg <= '0;
    end else if (tx_load || tx_unit_end) begin
      tx_cnt_reg <= '0;
    end else if (tx_busy_reg) begin
      tx_cnt_reg <= tx_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_reg <= 1'b0;
    end else if (tx_load) begin
      tx_busy_reg <= 1'b1;
    end else if (tx_end) begin
      tx_busy_reg <= 1'b0; // [RULE4]
    end
  end

  assign line_tx = tx_frame_reg[0];

  // Output status.
  logic prt_done_reg, prt_ie_reg, prt_req_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prt_done_reg <= 1'b1;
    end else if (tx_end) begin
      prt_done_reg <= 1'b1; // [RULE16]
    end else if (tx_load) begin
      prt_done_reg <= 1'b0; // [RULE15]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prt_ie_reg <= 1'b0;
    end else if (wr_pst) begin
      prt_ie_reg <= bus_req.wdata[sti_pkg::IE_BIT]; // [RULE20]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prt_req_reg <= 1'b0;
    end else if (prt_ie_reg && tx_end && !prt_done_reg) begin
      prt_req_reg <= 1'b1; // [RULE17]
    end else if (rd_pst) begin
      prt_req_reg <= 1'b0; // [RULE18]
    end
  end

  assign irq = key_req_reg || prt_req_reg; // [RULE13]

  // Poll response. The output half wins should both positions ever match.
  logic poll_prt_hit;
  logic poll_key_hit;
  assign poll_prt_hit = poll && poll_pos == sti_pkg::PRINT_POLL_POS;
  assign poll_key_hit = poll && poll_pos == sti_pkg::KEY_POLL_POS;

  always_comb begin
    poll_ack    = 1'b0;
    poll_vector = 8'h00;
    if (poll_prt_hit && prt_req_reg) begin
      poll_ack    = 1'b1; // [RULE6] [RULE19]
      poll_vector = sti_pkg::PRINT_VECTOR; // [RULE7]
    end else if (poll_key_hit && key_req_reg) begin
      poll_ack    = 1'b1; // [RULE6] [RULE19]
      poll_vector = sti_pkg::KEY_VECTOR; // [RULE7]
    end
  end

  // Register read data.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req.rd || bus_req.wr;
    end
  end

  // Unmapped reads return zero rather than stale data.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (rd_kin) begin
      bus_rdata <= key_input_buffer_reg;
    end else if (rd_kst) begin
      bus_rdata <= status_byte(key_done_reg, key_err_reg); // [RULE21]
    end else if (rd_pst) begin
      bus_rdata <= status_byte(prt_done_reg, prt_ie_reg); // [RULE21]
    end else begin
      bus_rdata <= 8'h00;
    end
  end

endmodule : serial_terminal_interface

//--- logic/sti_pkg.sv
// Summary of operation
// RULE1: Characters are eight bits; seven-bit codes carry a forced one in bit seven.
// RULE2: The terminal printer ignores bit seven, sent as one or odd parity.
// RULE3: Characters pass both ways unaltered, with no code conversion.
// RULE4: Each character is an 11-unit serial frame at ten characters per second.
// RULE5: Frame is one start space, eight data bits LSB first, two stop marks.
// RULE6: Output half answers poll position 2, input half poll position 1.
// RULE7: Transfer vectors sit at 244-247 for output, 248-251 for input.
// RULE8: A fully received character sets the input done flag.
// RULE9: Reading the input buffer clears input done and error flags.
// RULE10: A character arriving while input done is set raises the error flag.
// RULE11: Software must read the input buffer within 100 ms of done.
// RULE12: With interrupts enabled, rising input done or error sets the input request.
// RULE13: A set input request drives the single serial interrupt level.
// RULE14: Reading the input status register clears the input request.
// RULE15: Writing the output buffer starts transmission and clears output done.
// RULE16: Output done sets again only after the character is fully sent.
// RULE17: With interrupts enabled, rising output done sets the output request.
// RULE18: Reading the output status register clears the output request.
// RULE19: Each half answers polls of its level while its request is set.
// RULE20: Each status register holds an interrupt enable gating request creation.
// RULE21: Done sits in bit seven of each status byte.
package sti_pkg;

  localparam logic [15:0] KEY_STATUS_ADDR   = 16'hFFF0;
  localparam logic [15:0] KEY_INPUT_ADDR    = 16'hFFF2;
  localparam logic [15:0] PRINT_STATUS_ADDR = 16'hFFF4;
  localparam logic [15:0] PRINT_OUTPUT_ADDR = 16'hFFF6;

  localparam int DONE_BIT  = 7;
  localparam int ERROR_BIT = 6;
  localparam int IE_BIT    = 6;

  localparam logic [2:0] KEY_POLL_POS   = 3'h1;
  localparam logic [2:0] PRINT_POLL_POS = 3'h2;
  localparam logic [7:0] KEY_VECTOR     = 8'hF8;
  localparam logic [7:0] PRINT_VECTOR   = 8'hF4;

  localparam int CLK_HZ         = 10000000;
  localparam int CHAR_PER_SEC   = 10;
  localparam int FRAME_UNITS    = 11;
  localparam int UNIT_CYCLES    = CLK_HZ / (CHAR_PER_SEC * FRAME_UNITS);
  localparam int HALF_UNIT      = UNIT_CYCLES / 2;
  localparam int DATA_BITS      = 8;
  localparam int STOP_UNITS     = 2;

  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } bus_req_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

endpackage : sti_pkg

//--- sim/serial_terminal_interface_asserts.sv
`timescale 1ns/100ps
module sti_asserts #(
  parameter int UNIT_CYCLES = 16
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire sti_pkg::bus_req_t bus_req,
  input wire logic [7:0]        bus_rdata,
  input wire logic              bus_ack,
  input wire logic              poll,
  input wire logic [2:0]        poll_pos,
  input wire logic              poll_ack,
  input wire logic [7:0]        poll_vector,
  input wire logic              irq,
  input wire logic              line_rx,
  input wire logic              line_tx
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_ks = bus_req.rd && bus_req.addr == sti_pkg::KEY_STATUS_ADDR;
  wire rd_kb = bus_req.rd && bus_req.addr == sti_pkg::KEY_INPUT_ADDR;
  wire rd_ps = bus_req.rd && bus_req.addr == sti_pkg::PRINT_STATUS_ADDR;
  wire wr_pb = bus_req.wr && bus_req.addr == sti_pkg::PRINT_OUTPUT_ADDR;
  wire p_key = poll && poll_pos == sti_pkg::KEY_POLL_POS;
  wire p_prt = poll && poll_pos == sti_pkg::PRINT_POLL_POS;
  AST_POLL_KEY: assert property (
    p_key && poll_ack |-> poll_vector == sti_pkg::KEY_VECTOR) else $error("key vector wrong");
  AST_POLL_PRINT: assert property (
    p_prt && poll_ack |-> poll_vector == sti_pkg::PRINT_VECTOR) else $error("print vector wrong");
  AST_POLL_NONE: assert property (
    poll && !p_key && !p_prt |-> !poll_ack) else $error("foreign poll answered");
  AST_IRQ_POLL: assert property (
    !irq |-> !poll_ack) else $error("poll answered without request");
  AST_START: assert property (
    $fell(line_tx) |-> !line_tx [*8]) else $error("start unit too short");
  AST_HOLD: assert property (
    $rose(line_tx) |=> $stable(line_tx) [*8]) else $error("unit too short");
  AST_DONE_CLR: assert property (
    wr_pb ##2 rd_ps |=> !bus_rdata[sti_pkg::DONE_BIT]) else $error("print done not cleared");
  AST_KEY_CLR: assert property (
    rd_kb ##2 rd_ks |=> bus_rdata[7:6] == 2'b00) else $error("key flags not cleared");
endmodule : sti_asserts

bind serial_terminal_interface sti_asserts #(.UNIT_CYCLES(UNIT_CYCLES)) u_asserts (
  .clk(clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
  .poll(poll), .poll_pos(poll_pos), .poll_ack(poll_ack), .poll_vector(poll_vector),
  .irq(irq), .line_rx(line_rx), .line_tx(line_tx));

//--- sim/terminal_model.sv
`timescale 1ns/100ps
module terminal_model #(
  parameter int UNIT_CYCLES = 16
) (
  input  wire logic clk,
  input  wire logic line_tx,
  output logic      line_rx
);
  logic [7:0] rx_byte = 8'h00;
  logic       stop_ok = 1'b0;
  initial line_rx = 1'b1;
  // Keyboard frame: start space, eight data units LSB first, two marks.
  task automatic send_char(input logic [7:0] c);
    logic [10:0] f;
    f = {2'b11, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_rx = f[i];
      repeat (UNIT_CYCLES) @(posedge clk);
      #10;
    end
  endtask : send_char
  // Printer keeps the whole byte, though it would ignore bit seven.
  initial forever begin
    @(negedge line_tx);
    repeat (UNIT_CYCLES / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (UNIT_CYCLES) @(posedge clk);
      rx_byte[i] = line_tx;
    end
    repeat (UNIT_CYCLES) @(posedge clk);
    stop_ok = line_tx;
  end
endmodule : terminal_model

//--- sim/serial_terminal_interface_tb_top.sv
`timescale 1ns/100ps
module serial_terminal_interface_tb_top;
  localparam int U = 16;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  sti_pkg::bus_req_t bus_req = '0;
  logic              poll = 1'b0;
  logic [2:0]        poll_pos = 3'h0;
  logic [7:0]        bus_rdata, poll_vector, d;
  logic              bus_ack, poll_ack, irq, line_rx, line_tx;
  int                bad_count = 0;
  int                n_compared = 0;
  int                n;
  always #50 clk = ~clk;
  serial_terminal_interface #(.UNIT_CYCLES(U)) dut (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .bus_ack(bus_ack), .poll(poll), .poll_pos(poll_pos), .poll_ack(poll_ack),
    .poll_vector(poll_vector), .irq(irq), .line_rx(line_rx), .line_tx(line_tx));
  terminal_model #(.UNIT_CYCLES(U)) u_term (.clk(clk), .line_tx(line_tx), .line_rx(line_rx));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] wd);
    @(posedge clk) #10;
    bus_req = '{rd: !w, wr: w, addr: a, wdata: wd};
    @(posedge clk) #10;
    bus_req = '0;
    d = bus_rdata;
  endtask : bus
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check({7'h00, bus_ack}, 8'h01);
    check(d, e);
  endtask : rdc
  task automatic do_poll(input logic [2:0] pos, input logic [7:0] vec);
    @(posedge clk) #10;
    poll = 1'b1;
    poll_pos = pos;
    @(posedge clk) #10;
    check({7'h00, poll_ack}, {7'h00, vec != 8'h00});
    if (vec != 8'h00) check(poll_vector, vec);
    poll = 1'b0;
  endtask : do_poll
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic t_reset();
    rdc(sti_pkg::PRINT_STATUS_ADDR, 8'h80);
    rdc(sti_pkg::KEY_STATUS_ADDR, 8'h00);
    rdc(16'hFFF8, 8'h00);
  endtask : t_reset
  // Buffer is read at once, well inside the allowed latency.
  task automatic t_rx();
    u_term.send_char(8'hC1);
    check({7'h00, irq}, 8'h00);
    rdc(sti_pkg::KEY_STATUS_ADDR, 8'h80);
    rdc(sti_pkg::KEY_INPUT_ADDR, 8'hC1);
    rdc(sti_pkg::KEY_STATUS_ADDR, 8'h00);
  endtask : t_rx
  task automatic t_overrun();
    bus(1'b1, sti_pkg::KEY_STATUS_ADDR, 8'h40);
    u_term.send_char(8'hB5);
    check({7'h00, irq}, 8'h01);
    do_poll(sti_pkg::KEY_POLL_POS, sti_pkg::KEY_VECTOR);
    do_poll(3'h3, 8'h00);
    rdc(sti_pkg::KEY_STATUS_ADDR, 8'h80);
    check({7'h00, irq}, 8'h00);
    u_term.send_char(8'h8D);
    check({7'h00, irq}, 8'h01);
    rdc(sti_pkg::KEY_STATUS_ADDR, 8'hC0);
    bus(1'b0, sti_pkg::KEY_INPUT_ADDR, 8'h00);
    rdc(sti_pkg::KEY_STATUS_ADDR, 8'h00);
    bus(1'b1, sti_pkg::KEY_STATUS_ADDR, 8'h00);
  endtask : t_overrun
  // A second write while the frame is out must be dropped, so the byte seen is the first.
  task automatic t_tx();
    bus(1'b1, sti_pkg::PRINT_STATUS_ADDR, 8'h40);
    bus(1'b1, sti_pkg::PRINT_OUTPUT_ADDR, 8'h55);
    rdc(sti_pkg::PRINT_STATUS_ADDR, 8'h40);
    bus(1'b1, sti_pkg::PRINT_OUTPUT_ADDR, 8'hAA);
    for (n = 0; n < 12 * U && irq !== 1'b1; n++) @(posedge clk) #10;
    if (n == 12 * U) begin
      bad_count++;
      print_verdict();
    end
    check({7'h00, n > 10 * U}, 8'h01);
    check(u_term.rx_byte, 8'h55);
    check({7'h00, u_term.stop_ok}, 8'h01);
    do_poll(sti_pkg::PRINT_POLL_POS, sti_pkg::PRINT_VECTOR);
    rdc(sti_pkg::PRINT_STATUS_ADDR, 8'hC0);
    check({7'h00, irq}, 8'h00);
  endtask : t_tx
  initial begin
    repeat (5) @(posedge clk);
    #10 rst_n = 1'b1;
    t_reset();
    t_rx();
    t_overrun();
    t_tx();
    print_verdict();
  end
endmodule : serial_terminal_interface_tb_top
